// ### sim/spio_board.sv
`timescale 1ns/1ps
`default_nettype none
// board side of the pins: device drive, then board drive, then pullup
module spio_board (
  input wire logic clk,
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe,
  input wire logic [47:0] pin_pullup,
  input wire logic [47:0] ext_val,
  input wire logic [47:0] ext_drv,
  output logic [47:0] pin_in
);
  logic [47:0] flt_q = 48'h0;

  // a floating line shows the inverse of its last level, never a stale one
  always_comb begin
    for (int i = 0; i < 48; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_drv[i] ? ext_val[i] : pin_pullup[i] | flt_q[i];
    end
  end

  always_ff @(posedge clk) begin
    flt_q <= ~pin_in;
  end
endmodule
`default_nettype wire

// ### sim/spio_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ownership checks at the top ports; three settled cycles hide pipeline depth
module spio_sva (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [7:0] kbd_enable,
  input wire logic adc_on,
  input wire logic [7:0] adc_pin_enable,
  input wire logic async_serial_unit_two_on,
  input wire logic async_serial_unit_two_txd,
  input wire logic i2c_on,
  input wire logic i2c_sda_oe,
  input wire logic spi_on,
  input wire logic [3:0] spi_oe,
  input wire logic bkgd_oe,
  input wire logic background_pin_enable,
  input wire logic [47:0] pin_out,
  input wire logic [47:0] pin_oe,
  input wire logic [47:0] pin_pullup
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // outputs still hold reset values at the release edge
  a_reset_idle: assert property ($rose(rst_b) |-> pin_oe == 48'h0 && pin_pullup == 48'h0)
    else $error("pins not idle at reset release");
  a_reset_bkgd: assert property ($rose(rst_b) |-> background_pin_enable)
    else $error("background enable not set at reset release");
  a_kbd_input: assert property ((ce && $stable(kbd_enable))[*3] |-> (pin_oe[7:0] & kbd_enable) == 8'h00)
    else $error("keyboard pin drives");
  a_adc_input: assert property ((ce && adc_on && $stable(adc_pin_enable))[*3]
    |-> (pin_oe[15:8] & adc_pin_enable) == 8'h00)
    else $error("analog pin drives");
  a_async_serial_unit_two_tx: assert property ((ce && async_serial_unit_two_on && $stable(async_serial_unit_two_txd))[*3]
    |-> pin_oe[16] && !pin_oe[17] && pin_out[16] == async_serial_unit_two_txd)
    else $error("serial two pins wrong");
  a_sda_dir: assert property ((ce && i2c_on && $stable(i2c_sda_oe))[*3] |-> pin_oe[18] == i2c_sda_oe)
    else $error("data line direction wrong");
  a_spi_dir: assert property ((ce && spi_on && $stable(spi_oe))[*3] |-> pin_oe[37:34] == spi_oe)
    else $error("spi direction wrong");
  a_bkgd_pull: assert property ((ce && background_pin_enable)[*3] |-> pin_pullup[40])
    else $error("background pullup off");
  a_bkgd_dir: assert property ((ce && background_pin_enable && $stable(bkgd_oe))[*3]
    |-> pin_oe[40] == bkgd_oe)
    else $error("background direction wrong");
  a_unused_bits: assert property ({pin_oe[47:44], pin_oe[39:38], pin_oe[31:29],
    pin_out[47:44], pin_out[39:38], pin_out[31:29]} == 18'h0)
    else $error("unimplemented pin active");

  // main scenarios reached
  c_kbd: cover property (kbd_enable != 8'h00);
  c_serial: cover property (async_serial_unit_two_on && i2c_on);
  c_spi: cover property (spi_on);
  c_gpio_g0: cover property (!background_pin_enable);
endmodule

bind spio_ports spio_sva u_sva (.clk, .rst_b, .ce, .kbd_enable, .adc_on, .adc_pin_enable, .async_serial_unit_two_on,
  .async_serial_unit_two_txd, .i2c_on, .i2c_sda_oe, .spi_on, .spi_oe, .bkgd_oe, .background_pin_enable, .pin_out,
  .pin_oe, .pin_pullup);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import spio_pkg::*;
  localparam logic [3:0] KD = 4'h8;
  localparam logic [3:0] KR = 4'h4;
  localparam logic [3:0] KP = 4'h2;
  localparam logic [3:0] KS = 4'h1;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  spio_wr_s wr = '0;
  logic [2:0] rd_port = '0;
  logic background_pin_enable_wr = 1'b0, background_pin_enable_wdata = 1'b0;
  logic [7:0] kbd_enable = '0, adc_pin_enable = '0;
  logic adc_on = 1'b0, async_serial_unit_two_on = 1'b0, async_serial_unit_two_txd = 1'b0, i2c_on = 1'b0, i2c_sda_out = 1'b0;
  logic i2c_sda_oe = 1'b0, i2c_scl_out = 1'b0, i2c_scl_oe = 1'b0;
  logic [2:0] tmr1_own = '0, tmr1_oe = '0, tmr1_out = '0, tmr1_in;
  logic [1:0] tmr2_own = '0, tmr2_oe = '0, tmr2_out = '0, tmr2_in;
  logic async_serial_unit_one_on = 1'b0, async_serial_unit_one_txd = 1'b0, spi_on = 1'b0, bkgd_oe = 1'b0, bkgd_out = 1'b0, osc_on = 1'b0;
  logic [3:0] spi_oe = '0, spi_out = '0, spi_in;
  logic [7:0] rd_data, rd_dir, rd_pull, rd_slew;
  logic background_pin_enable, mode_select_sampled, async_serial_unit_two_rxd, i2c_sda_in, i2c_scl_in, async_serial_unit_one_rxd, bkgd_in;
  logic [47:0] pin_in, pin_out, pin_oe, pin_pullup, pin_slew, ext_val, ext_drv;
  int checked = 0, n_mismatch = 0;

  spio_ports #(.NPINS(39)) u_dut (.clk, .rst_b, .ce, .wr, .rd_port, .rd_data, .rd_dir, .rd_pull, .rd_slew,
    .background_pin_enable_wr, .background_pin_enable_wdata, .background_pin_enable, .mode_select_sampled,
    .kbd_enable, .adc_on, .adc_pin_enable, .async_serial_unit_two_on, .async_serial_unit_two_txd, .async_serial_unit_two_rxd, .i2c_on, .i2c_sda_out,
    .i2c_sda_oe, .i2c_scl_out, .i2c_scl_oe, .i2c_sda_in, .i2c_scl_in, .tmr1_own, .tmr1_oe, .tmr1_out,
    .tmr1_in, .tmr2_own, .tmr2_oe, .tmr2_out, .tmr2_in, .async_serial_unit_one_on, .async_serial_unit_one_txd, .async_serial_unit_one_rxd, .spi_on, .spi_oe,
    .spi_out, .spi_in, .bkgd_oe, .bkgd_out, .bkgd_in, .osc_on, .pin_in, .pin_out, .pin_oe, .pin_pullup,
    .pin_slew);
  spio_board u_board (.clk, .pin_out, .pin_oe, .pin_pullup, .ext_val, .ext_drv, .pin_in);

  always #4 clk = ~clk;

  task automatic step(int n);
    repeat (n) @(negedge clk);
  endtask

  // one strobe over one rising edge, then a quiet edge so calls can follow
  task automatic wreg(logic [2:0] p, logic [3:0] k, logic [7:0] d);
    wr <= '{p, k[3], k[2], k[1], k[0], d};
    @(negedge clk);
    wr <= '0;
    @(negedge clk);
  endtask

  task automatic chk(string nm, logic [47:0] e, logic [47:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog at 2500 cycles, well beyond the fewer than 100 cycles the tests need
  initial begin
    #20000;
    n_mismatch++;
    stop_test();
  end

  initial begin
    ext_val = 48'h0100_0000_0000;
    ext_drv = 48'h0100_0000_0000;
    step(5);
    chk("rst_oe", 48'h0, pin_oe);
    chk("rst_pull", 48'h0, pin_pullup);
    chk("rst_bpe", 1'b1, background_pin_enable);
    rst_b = 1'b1;
    step(3);
    chk("mode_strap", 1'b1, mode_select_sampled);
    chk("idle_oe", 48'h0, pin_oe);
    chk("g0_pull", 48'h0100_0000_0000, pin_pullup);
    // port A: latch written while input, then driven, then keyboard claims
    ext_val[7:0] = 8'h5a;
    ext_drv[7:0] = 8'hff;
    wreg(3'(PA), KD, 8'h3c);
    step(3);
    chk("a_rd_in", 8'h5a, rd_data);
    chk("a_oe_in", 8'h00, pin_oe[7:0]);
    wreg(3'(PA), KR, 8'hff);
    step(3);
    chk("a_out", 8'h3c, pin_out[7:0]);
    chk("a_rd_latch", 8'h3c, rd_data);
    kbd_enable = 8'h0f;
    step(3);
    chk("a_kbd_oe", 8'hf0, pin_oe[7:0]);
    chk("a_kbd_rd", 8'h3c, rd_data);
    // port B: analog select only while converter on
    rd_port = 3'(PB);
    wreg(3'(PB), KD, 8'ha5);
    wreg(3'(PB), KR, 8'hff);
    adc_on = 1'b1;
    adc_pin_enable = 8'h81;
    // four edges so the settled-select window of the checker is reached
    step(4);
    chk("b_adc_oe", 8'h7e, pin_oe[15:8]);
    adc_on = 1'b0;
    step(3);
    chk("b_adc_off", 8'hff, pin_oe[15:8]);
    chk("b_rd", 8'ha5, rd_data);
    // port C: serial two and i2c, C1 and C3 held high by the board
    rd_port = 3'(PC);
    wreg(3'(PC), KP, 8'hf0);
    async_serial_unit_two_on = 1'b1;
    async_serial_unit_two_txd = 1'b1;
    i2c_on = 1'b1;
    i2c_sda_oe = 1'b1;
    ext_val[23:16] = 8'h0a;
    ext_drv[23:16] = 8'h0a;
    step(4);
    chk("c_oe", 8'h05, pin_oe[23:16]);
    chk("c_tx", 8'h01, pin_out[23:16] & 8'h05);
    chk("c_pull", 4'hf, pin_pullup[23:20]);
    chk("c_in", 3'h6, {async_serial_unit_two_rxd, i2c_scl_in, i2c_sda_in});
    // port D: width limit, then timer claims over a driven port
    rd_port = 3'(PD);
    wreg(3'(PD), KR, 8'hff);
    step(3);
    chk("d_dir", 8'h1f, rd_dir);
    chk("d_oe", 8'h1f, pin_oe[31:24]);
    tmr1_own = 3'h7;
    tmr1_oe = 3'h5;
    tmr1_out = 3'h5;
    tmr2_own = 2'h3;
    tmr2_oe = 2'h2;
    ext_val[31:24] = 8'h0a;
    ext_drv[31:24] = 8'h0a;
    wreg(3'(PD), KD, 8'h1f);
    step(4);
    chk("d_oe_t", 8'h15, pin_oe[31:24]);
    chk("d_out_t", 8'h05, pin_out[31:24] & 8'h15);
    chk("d_in_t", 5'h0f, {tmr2_in, tmr1_in});
    chk("d_rd", 8'h1f, rd_data);
    // port E: serial one and spi, E1 and E2 held high
    async_serial_unit_one_on = 1'b1;
    async_serial_unit_one_txd = 1'b1;
    spi_on = 1'b1;
    spi_oe = 4'ha;
    spi_out = 4'h8;
    ext_val[39:32] = 8'h06;
    ext_drv[39:32] = 8'h06;
    step(4);
    chk("e_oe", 8'h29, pin_oe[39:32]);
    chk("e_out", 8'h21, pin_out[39:32] & 8'h29);
    chk("e_in", 2'h3, {spi_in[0], async_serial_unit_one_rxd});
    // port G: background and oscillator own, then G0 handed to software
    rd_port = 3'(PG);
    ext_drv[47:40] = 8'h00;
    wreg(3'(PG), KR, 8'h09);
    osc_on = 1'b1;
    bkgd_oe = 1'b1;
    step(4);
    chk("g_oe", 4'h9, pin_oe[43:40]);
    chk("g_osc", 2'h0, pin_oe[42:41]);
    chk("g_pull", 4'h1, pin_pullup[43:40]);
    background_pin_enable_wr = 1'b1;
    step(1);
    background_pin_enable_wr = 1'b0;
    wreg(3'(PG), KD, 8'h01);
    step(3);
    chk("g_bpe", 1'b0, background_pin_enable);
    chk("g0_drive", 2'h3, {pin_oe[40], pin_out[40]});
    chk("g0_rd", 1'b1, rd_data[0]);
    chk("g0_in", 1'b1, bkgd_in);
    // slew only on driven pins, pullup only on inputs; G1 still owned by the oscillator
    wreg(3'(PG), KS, 8'h0f);
    wreg(3'(PG), KP, 8'h02);
    step(3);
    chk("g_rd_slew", 8'h0f, rd_slew);
    chk("g_slew", 4'h9, pin_slew[43:40]);
    chk("g_rd_pull", 8'h02, rd_pull);
    chk("g_pull2", 4'h2, pin_pullup[43:40]);
    // a write while the clock enable is low must not land
    ce = 1'b0;
    wreg(3'(PG), KD, 8'h00);
    chk("ce_hold", 1'b1, pin_out[40]);
    ce = 1'b1;
    step(3);
    chk("ce_drop", 1'b1, pin_out[40]);
    stop_test();
  end
endmodule
`default_nettype wire

// ### verilog/spio_pkg.sv
package spio_pkg;
  // port indices and widths
  localparam int NPORT = 6;
  localparam int PA = 0;
  localparam int PB = 1;
  localparam int PC = 2;
  localparam int PD = 3;
  localparam int PE = 4;
  localparam int PG = 5;
  localparam int WA = 8;
  localparam int WB = 8;
  localparam int WC = 8;
  localparam int WD = 5;
  localparam int WE = 6;
  localparam int WG = 4;
  localparam int TOTAL_PINS = 39;
  localparam int PW = 8;
  // bit positions of shared functions
  localparam int C_TXD2 = 0;
  localparam int C_RXD2 = 1;
  localparam int C_SDA = 2;
  localparam int C_SCL = 3;
  localparam int D_T1_LO = 0;
  localparam int D_T1_HI = 2;
  localparam int D_T2_LO = 3;
  localparam int D_T2_HI = 4;
  localparam int D_T1_CLK = 0;
  localparam int D_T2_CLK = 3;
  localparam int E_TXD1 = 0;
  localparam int E_RXD1 = 1;
  localparam int E_SS = 2;
  localparam int E_MISO = 3;
  localparam int E_MOSI = 4;
  localparam int E_SCK = 5;
  localparam int G_BKGD = 0;
  localparam int G_XTAL = 1;
  localparam int G_EXTAL = 2;
  // reset values
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] PULL_RST = 8'h00;
  localparam logic [7:0] SLEW_RST = 8'h00;
  localparam logic BKGD_PE_RST = 1'b1;
  localparam logic [7:0] ALL_ZERO = 8'h00;
  localparam logic [7:0] ALL_ONE = 8'hff;

  // software write port for one port's register set
  typedef struct packed {
    logic [2:0] port;
    logic data_we;
    logic dir_we;
    logic pull_we;
    logic slew_we;
    logic [7:0] wdata;
  } spio_wr_s;

  // one port's peripheral pin claims: owns, drives, output enable, pullup
  typedef struct packed {
    logic [7:0] own;
    logic [7:0] oe;
    logic [7:0] out;
    logic [7:0] pull;
  } spio_claim_s;
endpackage

// ### verilog/spio_ports.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// (R1) 39 pins in six ports, one output-only
// (R2) widths A,B,C=8, D=5, E=6, G=4
// (R3) reset clears direction and pullup enables
// (R4) background function owns its pin after reset
// (R5) all other peripheral functions start disabled
// (R6) keyboard-enabled port A pins forced input
// (R7) converter-enabled port B pins forced input
// (R8) serial two and I2C control port C direction
// (R9) serial two: C0 transmit, C1 receive
// (R10) I2C: C2 data, C3 clock
// (R11) enabled timers control port D direction
// (R12) timer two uses D4,D3; clock D3 only
// (R13) timer one uses D2..D0; clock D0 only
// (R14) serial one and SPI control port E direction
// (R15) serial one: E0 transmit, E1 receive
// (R16) SPI: E2 select, E3 MISO, E4 MOSI, E5 clock
// (R17) background and oscillator control port G direction
// (R18) background enabled keeps G0 pullup on
// (R19) background pin samples mode at reset release
// (R20) clock generator takes G2,G1 for crystal
// (R21) read returns pin if input, latch if output; G0 always returns its pin
// (R22) data writes always update the latch
// (R23) latch driven only unowned and output
// (R24) direction bit picks read source regardless
// (R25) pin reads pass a two-flop synchroniser
module spio_ports
  import spio_pkg::*;
#(
  parameter int NPINS = 39
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // software access
  input wire spio_pkg::spio_wr_s wr,
  input wire logic [2:0] rd_port,
  output logic [7:0] rd_data,
  output logic [7:0] rd_dir,
  output logic [7:0] rd_pull,
  output logic [7:0] rd_slew,
  // system options and peripheral enables
  input wire logic background_pin_enable_wr,
  input wire logic background_pin_enable_wdata,
  output logic background_pin_enable,
  output logic mode_select_sampled,
  input wire logic [7:0] kbd_enable,
  input wire logic adc_on,
  input wire logic [7:0] adc_pin_enable,
  input wire logic async_serial_unit_two_on,
  input wire logic async_serial_unit_two_txd,
  output logic async_serial_unit_two_rxd,
  input wire logic i2c_on,
  input wire logic i2c_sda_out,
  input wire logic i2c_sda_oe,
  input wire logic i2c_scl_out,
  input wire logic i2c_scl_oe,
  output logic i2c_sda_in,
  output logic i2c_scl_in,
  input wire logic [2:0] tmr1_own,
  input wire logic [2:0] tmr1_oe,
  input wire logic [2:0] tmr1_out,
  output logic [2:0] tmr1_in,
  input wire logic [1:0] tmr2_own,
  input wire logic [1:0] tmr2_oe,
  input wire logic [1:0] tmr2_out,
  output logic [1:0] tmr2_in,
  input wire logic async_serial_unit_one_on,
  input wire logic async_serial_unit_one_txd,
  output logic async_serial_unit_one_rxd,
  input wire logic spi_on,
  input wire logic [3:0] spi_oe,
  input wire logic [3:0] spi_out,
  output logic [3:0] spi_in,
  input wire logic bkgd_oe,
  input wire logic bkgd_out,
  output logic bkgd_in,
  input wire logic osc_on,
  // pins, flat over ports, port A in [7:0]
  input wire logic [47:0] pin_in,
  output logic [47:0] pin_out,
  output logic [47:0] pin_oe,
  output logic [47:0] pin_pullup,
  output logic [47:0] pin_slew
);
  localparam logic [7:0] WIDTH_MASK [NPORT] = '{8'hff, 8'hff, 8'hff, 8'h1f, 8'h3f, 8'h0f}; // (R2)

  if (NPINS != TOTAL_PINS) begin : g_bad_npins
    $error("spio_ports: pin count must be 39"); // (R1)
  end

  // implemented-bit mask for a port
  function automatic logic [7:0] pmask(input int p);
    return WIDTH_MASK[p];
  endfunction

  logic [7:0] data_q [NPORT];
  logic [7:0] data_d [NPORT];
  logic [7:0] dir_q [NPORT];
  logic [7:0] dir_d [NPORT];
  logic [7:0] pull_q [NPORT];
  logic [7:0] pull_d [NPORT];
  logic [7:0] slew_q [NPORT];
  logic [7:0] slew_d [NPORT];
  logic bkpe_q, bkpe_d;
  logic ms_q, ms_d, ms_done_q, ms_done_d;
  logic [47:0] pin_sync;
  spio_claim_s claim [NPORT];
  logic [47:0] out_d, oe_d, pu_d, sl_d;
  logic [47:0] out_q, oe_q, pu_q, sl_q;
  logic [7:0] rdd_d, rdr_d, rdp_d, rds_d;
  logic [7:0] rdd_q, rdr_q, rdp_q, rds_q;
  logic [13:0] fin_d, fin_q;

  // register writes, per port
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      data_d[p] = data_q[p];
      dir_d[p] = dir_q[p];
      pull_d[p] = pull_q[p];
      slew_d[p] = slew_q[p];
      if (ce && wr.port == 3'(p)) begin
        if (wr.data_we) data_d[p] = wr.wdata & pmask(p); // (R22)
        if (wr.dir_we) dir_d[p] = wr.wdata & pmask(p);
        if (wr.pull_we) pull_d[p] = wr.wdata & pmask(p);
        if (wr.slew_we) slew_d[p] = wr.wdata & pmask(p);
      end
    end
    // bit 0 of port G cannot be an input; its direction reads as output
    if (ce) dir_d[PG][G_BKGD] = 1'b1; // (R1)
    bkpe_d = (ce && background_pin_enable_wr) ? background_pin_enable_wdata : bkpe_q;
    // mode strap caught on the first enabled edge after release
    ms_d = ms_q;
    ms_done_d = ms_done_q;
    if (ce && !ms_done_q) begin
      ms_d = pin_in[PG*PW + G_BKGD]; // (R19)
      ms_done_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int p = 0; p < NPORT; p++) begin
        data_q[p] <= DATA_RST;
        dir_q[p] <= DIR_RST; // (R3)
        pull_q[p] <= PULL_RST; // (R3)
        slew_q[p] <= SLEW_RST;
      end
      bkpe_q <= BKGD_PE_RST; // (R4)
      ms_q <= 1'b0;
      ms_done_q <= 1'b0;
    end else begin
      for (int p = 0; p < NPORT; p++) begin
        data_q[p] <= data_d[p];
        dir_q[p] <= dir_d[p];
        pull_q[p] <= pull_d[p];
        slew_q[p] <= slew_d[p];
      end
      bkpe_q <= bkpe_d;
      ms_q <= ms_d;
      ms_done_q <= ms_done_d;
    end
  end

  // pin levels for software reads are synchronised
  spio_sync #(.W(48)) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .ce(ce),
    .din(pin_in),
    .dout(pin_sync) // (R25)
  );

  // peripheral claims; enables arrive low from their own resets (R5)
  always_comb begin
    for (int p = 0; p < NPORT; p++) claim[p] = '0;
    claim[PA].own = kbd_enable; // (R6)
    claim[PB].own = adc_on ? adc_pin_enable : ALL_ZERO; // (R7)
    if (async_serial_unit_two_on) begin // (R8)
      claim[PC].own[C_TXD2] = 1'b1; // (R9)
      claim[PC].oe[C_TXD2] = 1'b1;
      claim[PC].out[C_TXD2] = async_serial_unit_two_txd;
      claim[PC].own[C_RXD2] = 1'b1;
    end
    if (i2c_on) begin // (R8)
      claim[PC].own[C_SDA] = 1'b1; // (R10)
      claim[PC].oe[C_SDA] = i2c_sda_oe;
      claim[PC].out[C_SDA] = i2c_sda_out;
      claim[PC].own[C_SCL] = 1'b1;
      claim[PC].oe[C_SCL] = i2c_scl_oe;
      claim[PC].out[C_SCL] = i2c_scl_out;
    end
    claim[PD].own[D_T1_HI:D_T1_LO] = tmr1_own; // (R11) (R13)
    claim[PD].oe[D_T1_HI:D_T1_LO] = tmr1_oe & tmr1_own;
    claim[PD].out[D_T1_HI:D_T1_LO] = tmr1_out;
    claim[PD].own[D_T2_HI:D_T2_LO] = tmr2_own; // (R11) (R12)
    claim[PD].oe[D_T2_HI:D_T2_LO] = tmr2_oe & tmr2_own;
    claim[PD].out[D_T2_HI:D_T2_LO] = tmr2_out;
    if (async_serial_unit_one_on) begin // (R14)
      claim[PE].own[E_TXD1] = 1'b1; // (R15)
      claim[PE].oe[E_TXD1] = 1'b1;
      claim[PE].out[E_TXD1] = async_serial_unit_one_txd;
      claim[PE].own[E_RXD1] = 1'b1;
    end
    if (spi_on) begin // (R14)
      claim[PE].own[E_SCK:E_SS] = 4'hf; // (R16)
      claim[PE].oe[E_SCK:E_SS] = spi_oe;
      claim[PE].out[E_SCK:E_SS] = spi_out;
    end
    if (bkpe_q) begin // (R17)
      claim[PG].own[G_BKGD] = 1'b1;
      claim[PG].oe[G_BKGD] = bkgd_oe;
      claim[PG].out[G_BKGD] = bkgd_out;
      claim[PG].pull[G_BKGD] = 1'b1; // (R18)
    end
    if (osc_on) begin // (R20)
      claim[PG].own[G_EXTAL] = 1'b1;
      claim[PG].own[G_XTAL] = 1'b1;
    end
  end

  // pin drive: owner decides, else latch when output
  always_comb begin
    for (int p = 0; p < NPORT; p++) begin
      for (int b = 0; b < PW; b++) begin
        if (claim[p].own[b]) begin
          oe_d[p*PW+b] = claim[p].oe[b];
          out_d[p*PW+b] = claim[p].out[b];
        end else begin
          oe_d[p*PW+b] = dir_q[p][b]; // (R23)
          out_d[p*PW+b] = dir_q[p][b] & data_q[p][b]; // (R23)
        end
        // pullup only on an input-configured pin, or forced by owner
        pu_d[p*PW+b] = claim[p].pull[b] | (pull_q[p][b] & ~dir_q[p][b]);
        sl_d[p*PW+b] = slew_q[p][b] & oe_d[p*PW+b];
      end
    end
    oe_d = oe_d & {WIDTH_MASK[PG], WIDTH_MASK[PE], WIDTH_MASK[PD],
                   WIDTH_MASK[PC], WIDTH_MASK[PB], WIDTH_MASK[PA]};
    out_d = out_d & oe_d;
    pu_d = pu_d & {WIDTH_MASK[PG], WIDTH_MASK[PE], WIDTH_MASK[PD],
                   WIDTH_MASK[PC], WIDTH_MASK[PB], WIDTH_MASK[PA]};
    if (!ce) begin
      oe_d = oe_q;
      out_d = out_q;
      pu_d = pu_q;
      sl_d = sl_q;
    end
  end

  // read mux and peripheral input returns; every pin level they take is synchronised
  always_comb begin
    rdd_d = rdd_q;
    rdr_d = rdr_q;
    rdp_d = rdp_q;
    rds_d = rds_q;
    fin_d = fin_q;
    if (ce) begin
      rdd_d = ALL_ZERO;
      rdr_d = ALL_ZERO;
      rdp_d = ALL_ZERO;
      rds_d = ALL_ZERO;
      for (int p = 0; p < NPORT; p++) begin
        if (rd_port == 3'(p)) begin
          // direction bit chooses source even under a peripheral
          rdd_d = (dir_q[p] & data_q[p]) | (~dir_q[p] & pin_sync[p*PW +: PW] & pmask(p)); // (R21) (R24)
          rdr_d = dir_q[p];
          rdp_d = pull_q[p];
          rds_d = slew_q[p];
        end
      end
      // output-only bit reads back the level on its pin
      if (rd_port == 3'(PG)) rdd_d[G_BKGD] = pin_sync[PG*PW + G_BKGD];
      fin_d[0] = pin_sync[PC*PW + C_RXD2];
      fin_d[1] = pin_sync[PC*PW + C_SDA];
      fin_d[2] = pin_sync[PC*PW + C_SCL];
      fin_d[5:3] = pin_sync[PD*PW + D_T1_LO +: 3];
      fin_d[7:6] = pin_sync[PD*PW + D_T2_LO +: 2];
      fin_d[8] = pin_sync[PE*PW + E_RXD1];
      fin_d[12:9] = pin_sync[PE*PW + E_SS +: 4];
      fin_d[13] = pin_sync[PG*PW + G_BKGD];
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_q <= '0;
      oe_q <= '0;
      pu_q <= '0;
      sl_q <= '0;
      rdd_q <= ALL_ZERO;
      rdr_q <= ALL_ZERO;
      rdp_q <= ALL_ZERO;
      rds_q <= ALL_ZERO;
      fin_q <= '0;
    end else begin
      out_q <= out_d;
      oe_q <= oe_d;
      pu_q <= pu_d;
      sl_q <= sl_d;
      rdd_q <= rdd_d;
      rdr_q <= rdr_d;
      rdp_q <= rdp_d;
      rds_q <= rds_d;
      fin_q <= fin_d;
    end
  end

  assign pin_out = out_q;
  assign pin_oe = oe_q;
  assign pin_pullup = pu_q;
  assign pin_slew = sl_q;
  assign rd_data = rdd_q;
  assign rd_dir = rdr_q;
  assign rd_pull = rdp_q;
  assign rd_slew = rds_q;
  assign background_pin_enable = bkpe_q;
  assign mode_select_sampled = ms_q;
  assign async_serial_unit_two_rxd = fin_q[0];
  assign i2c_sda_in = fin_q[1];
  assign i2c_scl_in = fin_q[2];
  assign tmr1_in = fin_q[5:3];
  assign tmr2_in = fin_q[7:6];
  assign async_serial_unit_one_rxd = fin_q[8];
  assign spi_in = fin_q[12:9];
  assign bkgd_in = fin_q[13];
endmodule
`default_nettype wire

// ### verilog/spio_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser for a vector of pin levels
module spio_sync #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] s1_q, s1_d, s2_q, s2_d;

  // first stage is only read by the second
  always_comb begin
    s1_d = ce ? din : s1_q;
    s2_d = ce ? s1_q : s2_q;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end

  assign dout = s2_q;
endmodule
`default_nettype wire
